// file: octal_uart_regs_cfg.svh
`ifndef OCTAL_UART_REGS_CFG_SVH
`define OCTAL_UART_REGS_CFG_SVH
// Behaviour
// R1 - Eight channels, each an eight-byte window at n times 0x08, up to 0x38.
// R2 - Line control bit 7 picks the bank decoded; line control shared by both.
// R3 - After reset every channel decodes its first bank.
// R4 - Bank 0: data, enables, ident/FIFO control, line, modem, status, scratch.
// R5 - Bank 1 and not 0xBF: offsets 0 and 1 are divisor low and high, read/write.
// R6 - Line control 0xBF: enhanced feature at 2, flow-on 4/5, flow-off 6/7.
// R7 - Offset 3 always reaches line control.
// R8 - Each channel has a 64-byte transmit FIFO and a 64-byte receive FIFO.
// R9 - Byte 0x40: receive ready of channels 3..0 high, transmit ready low.
// R10 - Byte 0x44: same layout for channels 7..4.
// R11 - Receive ready is 0 above trigger or on time-out, else 1.
// R12 - Transmit ready is 0 when full, 1 with any free location.
// R13 - Ready bytes show the live FIFO state, never latched.
// R14 - Byte 0x48 bit n shows channel n interrupt pending; resets to 0x00.
// R15 - All channel interrupts merge onto bridge local interrupt 1, then INTA.
// R16 - Host may poll the summary byte when bridge forwarding bit 6 is clear.
// R17 - Channel interrupt sources enable individually; all disabled after reset.
// R18 - Local reset out active during PCI reset or bridge software reset bit.
// R19 - Bit 30 holds local logic in reset; bridge configuration is not reset.
// R20 - After reset the bridge loads config from EEPROM bytes 0x00..0x87.
// R21 - Writes to read-only offsets ignored; write-only offsets read zero.

// --------------
// Address map
// --------------
`define OFS_DATA 3'h0
`define OFS_IER 3'h1
`define OFS_IIR_FCR 3'h2
`define OFS_LCR 3'h3
`define OFS_MCR 3'h4
`define OFS_LSR 3'h5
`define OFS_MSR 3'h6
`define OFS_SCR 3'h7
`define ADDR_READY_LOW 7'h40
`define ADDR_READY_HIGH 7'h44
`define ADDR_IRQ_SUMMARY 7'h48
`define BANK_SEL_BIT 7
`define LCR_FEATURE_KEY 8'hbf
`define CFG_ADDR_IRQ_CTRL 8'h4c
`define CFG_ADDR_CONTROL 8'h50
`define CFG_FWD_ENABLE_BIT 6
`define CFG_SW_RESET_BIT 30

// --------------
// Reset values and FIFO figures
// --------------
`define RST_BYTE 8'h00
`define RST_DIVISOR 8'hff
`define RST_SUMMARY 8'h00
`define FIFO_DEPTH 7'd64
`define RX_TRIG_0 7'd8
`define RX_TRIG_1 7'd16
`define RX_TRIG_2 7'd56
`define RX_TRIG_3 7'd60

// --------------
// Configuration EEPROM
// --------------
`define EE_LAST_ADDR 8'h87
`define EE_LOCAL_BASE 8'h28
`endif

// file: octal_uart_regs_pkg.sv
package octal_uart_regs_pkg;
    // Window slot selected by the bank decoder.
    typedef enum logic [3:0] {
        SEL_NONE, SEL_DATA, SEL_IER, SEL_IIR_FCR, SEL_LCR, SEL_MCR, SEL_LSR,
        SEL_MSR, SEL_SCR, SEL_DLL, SEL_DLM, SEL_EFR, SEL_XON1, SEL_XON2,
        SEL_XOFF1, SEL_XOFF2
    } sel_type;

    // Settings handed to one serial engine.
    typedef struct packed {
        logic [7:0] int_enable;
        logic [7:0] fifo_ctrl;
        logic [7:0] line_control_reg;
        logic [7:0] modem_ctrl;
        logic [7:0] divisor_low_byte;
        logic [7:0] divisor_high_byte;
        logic [7:0] enhanced_feature_reg;
        logic [7:0] flow_on_one;
        logic [7:0] flow_on_two;
        logic [7:0] flow_off_one;
        logic [7:0] flow_off_two;
    } chan_ctrl_type;

    // Status reported by one serial engine.
    typedef struct packed {
        logic [7:0] line_stat;
        logic [7:0] modem_stat;
        logic rx_timeout;
        logic line_irq;
        logic modem_irq;
    } chan_stat_type;

    typedef enum logic [1:0] {LD_REQ, LD_WAIT, LD_DONE} load_state_type;
endpackage

// file: octal_uart_regs.sv
`timescale 1ns/1ps
`include "octal_uart_regs_cfg.svh"

module octal_uart_regs (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [6:0] loc_addr_i,
    input wire logic loc_rd_i,
    input wire logic loc_wr_i,
    input wire logic [7:0] loc_wdata_i,
    output logic [7:0] loc_rdata_o,
    input wire logic [7:0] cfg_addr_i,
    input wire logic cfg_rd_i,
    input wire logic cfg_wr_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic ee_req_o,
    output logic [7:0] ee_addr_o,
    input wire logic ee_valid_i,
    input wire logic [7:0] ee_data_i,
    output logic cfg_loaded_o,
    output logic local_bus_reset_out_n_o,
    output logic local_irq1_o,
    output logic pci_inta_n_o,
    output octal_uart_regs_pkg::chan_ctrl_type chan_ctrl_o [8],
    input octal_uart_regs_pkg::chan_stat_type chan_stat_i [8],
    input wire logic [7:0] tx_pop_i,
    output logic [7:0] tx_valid_o,
    output logic [7:0] tx_data_o [8],
    input wire logic [7:0] rx_push_i,
    input wire logic [7:0] rx_data_i [8],
    output logic [7:0] rx_space_o
);

    // --------------
    // Window decoder
    // --------------

    // Maps a window offset to its register under the current line control.
    function automatic octal_uart_regs_pkg::sel_type decode_slot(
        input logic [7:0] line_control,
        input logic [2:0] ofs
    );
        octal_uart_regs_pkg::sel_type sel;
        sel = octal_uart_regs_pkg::SEL_NONE;
        if (ofs == `OFS_LCR) begin
            sel = octal_uart_regs_pkg::SEL_LCR; // R7
        end else if (line_control == `LCR_FEATURE_KEY) begin
            case (ofs) // R6
                3'h2: sel = octal_uart_regs_pkg::SEL_EFR;
                3'h4: sel = octal_uart_regs_pkg::SEL_XON1;
                3'h5: sel = octal_uart_regs_pkg::SEL_XON2;
                3'h6: sel = octal_uart_regs_pkg::SEL_XOFF1;
                3'h7: sel = octal_uart_regs_pkg::SEL_XOFF2;
                default: sel = octal_uart_regs_pkg::SEL_NONE;
            endcase
        end else if (line_control[`BANK_SEL_BIT]) begin
            case (ofs) // R5
                3'h0: sel = octal_uart_regs_pkg::SEL_DLL;
                3'h1: sel = octal_uart_regs_pkg::SEL_DLM;
                default: sel = octal_uart_regs_pkg::SEL_NONE;
            endcase
        end else begin
            case (ofs) // R4
                `OFS_DATA: sel = octal_uart_regs_pkg::SEL_DATA;
                `OFS_IER: sel = octal_uart_regs_pkg::SEL_IER;
                `OFS_IIR_FCR: sel = octal_uart_regs_pkg::SEL_IIR_FCR;
                `OFS_MCR: sel = octal_uart_regs_pkg::SEL_MCR;
                `OFS_LSR: sel = octal_uart_regs_pkg::SEL_LSR;
                `OFS_MSR: sel = octal_uart_regs_pkg::SEL_MSR;
                `OFS_SCR: sel = octal_uart_regs_pkg::SEL_SCR;
                default: sel = octal_uart_regs_pkg::SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    // --------------
    // Bridge configuration and reset
    // --------------

    logic [15:0] bridge_irq_ctrl_status_reg;
    logic [31:0] bridge_control_reg;
    logic [31:0] cfg_rdata_reg;
    octal_uart_regs_pkg::load_state_type load_state_reg;
    logic [7:0] ee_addr_reg;
    logic local_rst_n;
    logic [7:0] irq_ee_ofs;
    logic [7:0] ctl_ee_ofs;
    logic ee_take;

    // The local side stays in reset until the EEPROM image is in and while
    // software holds the reset bit; bridge registers only see the PCI reset.
    assign local_rst_n = rst_n_i & ~bridge_control_reg[`CFG_SW_RESET_BIT]
                         & (load_state_reg == octal_uart_regs_pkg::LD_DONE); // R19
    assign local_bus_reset_out_n_o = local_rst_n; // R18
    assign cfg_loaded_o = (load_state_reg == octal_uart_regs_pkg::LD_DONE);
    assign ee_req_o = (load_state_reg == octal_uart_regs_pkg::LD_WAIT);
    assign ee_addr_o = ee_addr_reg;
    assign cfg_rdata_o = cfg_rdata_reg;
    assign ee_take = ee_req_o & ee_valid_i;
    assign irq_ee_ofs = ee_addr_reg - (`EE_LOCAL_BASE + `CFG_ADDR_IRQ_CTRL);
    assign ctl_ee_ofs = ee_addr_reg - (`EE_LOCAL_BASE + `CFG_ADDR_CONTROL);

    // EEPROM walk: one byte per request, addresses 0x00 up to the last byte.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_state_reg <= octal_uart_regs_pkg::LD_REQ;
            ee_addr_reg <= 8'h00;
        end else begin
            case (load_state_reg) // R20
                octal_uart_regs_pkg::LD_REQ: load_state_reg <= octal_uart_regs_pkg::LD_WAIT;
                octal_uart_regs_pkg::LD_WAIT: begin
                    if (ee_valid_i && ee_addr_reg == `EE_LAST_ADDR) begin
                        load_state_reg <= octal_uart_regs_pkg::LD_DONE;
                    end else if (ee_valid_i) begin
                        ee_addr_reg <= ee_addr_reg + 8'h01;
                    end
                end
                octal_uart_regs_pkg::LD_DONE: load_state_reg <= octal_uart_regs_pkg::LD_DONE;
                default: load_state_reg <= octal_uart_regs_pkg::LD_REQ;
            endcase
        end
    end

    // Bridge registers: loaded from the image, later written by the host.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bridge_irq_ctrl_status_reg <= 16'h0000;
            bridge_control_reg <= 32'h0000_0000;
            cfg_rdata_reg <= 32'h0000_0000;
        end else begin
            if (ee_take && irq_ee_ofs < 8'd2) begin
                bridge_irq_ctrl_status_reg[irq_ee_ofs[0]*8 +: 8] <= ee_data_i; // R20
            end
            if (ee_take && ctl_ee_ofs < 8'd4) begin
                bridge_control_reg[ctl_ee_ofs[1:0]*8 +: 8] <= ee_data_i; // R20
            end
            if (cfg_wr_i && cfg_loaded_o && cfg_addr_i == `CFG_ADDR_IRQ_CTRL) begin
                bridge_irq_ctrl_status_reg <= cfg_wdata_i[15:0];
            end
            if (cfg_wr_i && cfg_loaded_o && cfg_addr_i == `CFG_ADDR_CONTROL) begin
                bridge_control_reg <= cfg_wdata_i; // R19
            end
            if (cfg_rd_i) begin
                cfg_rdata_reg <= (cfg_addr_i == `CFG_ADDR_CONTROL) ? bridge_control_reg :
                                 (cfg_addr_i == `CFG_ADDR_IRQ_CTRL) ?
                                 {16'h0000, bridge_irq_ctrl_status_reg} : 32'h0000_0000;
            end
        end
    end

    // --------------
    // Channel windows
    // --------------

    logic [7:0] chan_rdata [8];
    logic [7:0] rx_ready_flag;
    logic [7:0] tx_fifo_ready_flag;
    logic [7:0] chan_pending;
    logic [7:0] irq_summary_reg;
    logic [7:0] loc_rdata_reg;

    for (genvar ch = 0; ch < 8; ch++) begin : g_chan
        octal_uart_regs_pkg::chan_ctrl_type ctrl_reg;
        octal_uart_regs_pkg::sel_type sel;
        logic [7:0] scratch_reg;
        logic [7:0] tx_mem [64];
        logic [7:0] rx_mem [64];
        logic [5:0] tx_wp_reg;
        logic [5:0] tx_rp_reg;
        logic [6:0] tx_cnt_reg;
        logic [5:0] rx_wp_reg;
        logic [5:0] rx_rp_reg;
        logic [6:0] rx_cnt_reg;
        logic thr_irq_reg;
        logic hit;
        logic wr_hit;
        logic rd_hit;
        logic tx_push;
        logic tx_pop;
        logic rx_push;
        logic rx_pop;
        logic [6:0] trig;
        logic rx_irq;
        logic [3:0] ident;
        logic iir_read;

        // Address and slot decode for this window.
        assign hit = ~loc_addr_i[6] && loc_addr_i[5:3] == 3'(ch); // R1
        assign sel = decode_slot(ctrl_reg.line_control_reg, loc_addr_i[2:0]); // R2
        assign wr_hit = hit & loc_wr_i;
        assign rd_hit = hit & loc_rd_i;
        assign iir_read = rd_hit && sel == octal_uart_regs_pkg::SEL_IIR_FCR;

        // FIFO strobes; a push to a full FIFO or pop of an empty one is dropped.
        assign tx_push = wr_hit && sel == octal_uart_regs_pkg::SEL_DATA
                         && tx_cnt_reg != `FIFO_DEPTH;
        assign tx_pop = tx_pop_i[ch] && tx_cnt_reg != 7'd0;
        assign rx_push = rx_push_i[ch] && rx_cnt_reg != `FIFO_DEPTH;
        assign rx_pop = rd_hit && sel == octal_uart_regs_pkg::SEL_DATA && rx_cnt_reg != 7'd0;

        // Readiness is combinational from live counts, so reads see it now.
        assign trig = (ctrl_reg.fifo_ctrl[7:6] == 2'd0) ? `RX_TRIG_0 :
                      (ctrl_reg.fifo_ctrl[7:6] == 2'd1) ? `RX_TRIG_1 :
                      (ctrl_reg.fifo_ctrl[7:6] == 2'd2) ? `RX_TRIG_2 : `RX_TRIG_3;
        assign rx_ready_flag[ch] = ~(rx_cnt_reg > trig || chan_stat_i[ch].rx_timeout); // R11 R13
        assign tx_fifo_ready_flag[ch] = (tx_cnt_reg != `FIFO_DEPTH); // R12 R8
        assign tx_valid_o[ch] = (tx_cnt_reg != 7'd0);
        assign tx_data_o[ch] = tx_mem[tx_rp_reg];
        assign rx_space_o[ch] = (rx_cnt_reg != `FIFO_DEPTH);
        assign chan_ctrl_o[ch] = ctrl_reg;

        // Interrupt sources, each gated by its own enable bit, in priority.
        assign rx_irq = ctrl_reg.int_enable[0] & (rx_cnt_reg >= trig && rx_cnt_reg != 7'd0
                        || chan_stat_i[ch].rx_timeout & rx_cnt_reg != 7'd0); // R17
        assign ident = (ctrl_reg.int_enable[2] & chan_stat_i[ch].line_irq) ? 4'h6 :
                       rx_irq ? (chan_stat_i[ch].rx_timeout ? 4'hc : 4'h4) :
                       (ctrl_reg.int_enable[1] & thr_irq_reg) ? 4'h2 :
                       (ctrl_reg.int_enable[3] & chan_stat_i[ch].modem_irq) ? 4'h0 : 4'h1;
        assign chan_pending[ch] = ~ident[0];

        // Read data of this window; write-only slots read zero.
        always_comb begin
            case (sel) // R21
                octal_uart_regs_pkg::SEL_DATA: chan_rdata[ch] = rx_mem[rx_rp_reg];
                octal_uart_regs_pkg::SEL_IIR_FCR: chan_rdata[ch] =
                    {{2{ctrl_reg.fifo_ctrl[0]}}, 2'b00, ident};
                octal_uart_regs_pkg::SEL_LCR: chan_rdata[ch] = ctrl_reg.line_control_reg;
                octal_uart_regs_pkg::SEL_LSR: chan_rdata[ch] = chan_stat_i[ch].line_stat;
                octal_uart_regs_pkg::SEL_MSR: chan_rdata[ch] = chan_stat_i[ch].modem_stat;
                octal_uart_regs_pkg::SEL_SCR: chan_rdata[ch] = scratch_reg;
                octal_uart_regs_pkg::SEL_DLL: chan_rdata[ch] = ctrl_reg.divisor_low_byte;
                octal_uart_regs_pkg::SEL_DLM: chan_rdata[ch] = ctrl_reg.divisor_high_byte;
                octal_uart_regs_pkg::SEL_EFR: chan_rdata[ch] = ctrl_reg.enhanced_feature_reg;
                octal_uart_regs_pkg::SEL_XON1: chan_rdata[ch] = ctrl_reg.flow_on_one;
                octal_uart_regs_pkg::SEL_XON2: chan_rdata[ch] = ctrl_reg.flow_on_two;
                octal_uart_regs_pkg::SEL_XOFF1: chan_rdata[ch] = ctrl_reg.flow_off_one;
                octal_uart_regs_pkg::SEL_XOFF2: chan_rdata[ch] = ctrl_reg.flow_off_two;
                default: chan_rdata[ch] = 8'h00;
            endcase
        end

        // Host-writable settings; status slots take no write.
        always_ff @(posedge clk_sys_i or negedge local_rst_n) begin
            if (!local_rst_n) begin
                ctrl_reg <= '0; // R3 R17
                ctrl_reg.divisor_low_byte <= `RST_DIVISOR;
                ctrl_reg.divisor_high_byte <= `RST_DIVISOR;
                scratch_reg <= `RST_BYTE;
            end else if (wr_hit) begin
                case (sel) // R21
                    octal_uart_regs_pkg::SEL_IER: ctrl_reg.int_enable <= loc_wdata_i;
                    octal_uart_regs_pkg::SEL_IIR_FCR: ctrl_reg.fifo_ctrl <= loc_wdata_i;
                    octal_uart_regs_pkg::SEL_LCR: ctrl_reg.line_control_reg <= loc_wdata_i;
                    octal_uart_regs_pkg::SEL_MCR: ctrl_reg.modem_ctrl <= loc_wdata_i;
                    octal_uart_regs_pkg::SEL_SCR: scratch_reg <= loc_wdata_i;
                    octal_uart_regs_pkg::SEL_DLL: ctrl_reg.divisor_low_byte <= loc_wdata_i;
                    octal_uart_regs_pkg::SEL_DLM: ctrl_reg.divisor_high_byte <= loc_wdata_i;
                    octal_uart_regs_pkg::SEL_EFR: ctrl_reg.enhanced_feature_reg <= loc_wdata_i;
                    octal_uart_regs_pkg::SEL_XON1: ctrl_reg.flow_on_one <= loc_wdata_i;
                    octal_uart_regs_pkg::SEL_XON2: ctrl_reg.flow_on_two <= loc_wdata_i;
                    octal_uart_regs_pkg::SEL_XOFF1: ctrl_reg.flow_off_one <= loc_wdata_i;
                    octal_uart_regs_pkg::SEL_XOFF2: ctrl_reg.flow_off_two <= loc_wdata_i;
                    default: scratch_reg <= scratch_reg;
                endcase
            end
        end

        // FIFO pointers and counts; the storage itself carries no reset.
        always_ff @(posedge clk_sys_i or negedge local_rst_n) begin
            if (!local_rst_n) begin
                tx_wp_reg <= 6'd0;
                tx_rp_reg <= 6'd0;
                tx_cnt_reg <= 7'd0;
                rx_wp_reg <= 6'd0;
                rx_rp_reg <= 6'd0;
                rx_cnt_reg <= 7'd0;
            end else begin
                tx_wp_reg <= tx_wp_reg + 6'(tx_push);
                tx_rp_reg <= tx_rp_reg + 6'(tx_pop);
                tx_cnt_reg <= tx_cnt_reg + 7'(tx_push) - 7'(tx_pop); // R8
                rx_wp_reg <= rx_wp_reg + 6'(rx_push);
                rx_rp_reg <= rx_rp_reg + 6'(rx_pop);
                rx_cnt_reg <= rx_cnt_reg + 7'(rx_push) - 7'(rx_pop); // R8
            end
        end

        // FIFO storage writes.
        always_ff @(posedge clk_sys_i) begin
            if (tx_push) begin
                tx_mem[tx_wp_reg] <= loc_wdata_i;
            end
            if (rx_push) begin
                rx_mem[rx_wp_reg] <= rx_data_i[ch];
            end
        end

        // Transmit-empty event: armed when the FIFO drains, cleared by reading
        // the ident while it is shown or by new data; arming wins over an ident read, but a push in the same cycle stops it.
        always_ff @(posedge clk_sys_i or negedge local_rst_n) begin
            if (!local_rst_n) begin
                thr_irq_reg <= 1'b0;
            end else if (tx_pop && tx_cnt_reg == 7'd1 && !tx_push) begin
                thr_irq_reg <= 1'b1;
            end else if (tx_push || (iir_read && ident == 4'h2)) begin
                thr_irq_reg <= 1'b0;
            end
        end
    end

    // --------------
    // Shared status bytes and read port
    // --------------

    logic [7:0] ready_low;
    logic [7:0] ready_high;
    logic [7:0] rdata_next;

    assign ready_low = {rx_ready_flag[3:0], tx_fifo_ready_flag[3:0]}; // R9
    assign ready_high = {rx_ready_flag[7:4], tx_fifo_ready_flag[7:4]}; // R10
    assign rdata_next = ~loc_addr_i[6] ? chan_rdata[loc_addr_i[5:3]] :
                        (loc_addr_i == `ADDR_READY_LOW) ? ready_low :
                        (loc_addr_i == `ADDR_READY_HIGH) ? ready_high :
                        (loc_addr_i == `ADDR_IRQ_SUMMARY) ? irq_summary_reg : 8'h00;
    assign loc_rdata_o = loc_rdata_reg;

    // Merged interrupt: the summary is registered so a poll sees a clean byte.
    assign local_irq1_o = |irq_summary_reg; // R15
    assign pci_inta_n_o = ~(local_irq1_o & bridge_irq_ctrl_status_reg[`CFG_FWD_ENABLE_BIT]); // R16

    // Summary and read data capture.
    always_ff @(posedge clk_sys_i or negedge local_rst_n) begin
        if (!local_rst_n) begin
            irq_summary_reg <= `RST_SUMMARY; // R14
            loc_rdata_reg <= 8'h00;
        end else begin
            irq_summary_reg <= chan_pending; // R14
            if (loc_rd_i) begin
                loc_rdata_reg <= rdata_next; // R13
            end
        end
    end

endmodule

// file: octal_uart_regs_sva.sv
`timescale 1ns/1ps
// Port checker; it sees only the top-level pins of the register block.
module octal_uart_regs_sva (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [6:0] loc_addr_i,
    input wire logic loc_rd_i,
    input wire logic [7:0] loc_rdata_o,
    input wire logic [7:0] cfg_addr_i,
    input wire logic cfg_wr_i,
    input wire logic [31:0] cfg_wdata_i,
    input wire logic ee_req_o,
    input wire logic [7:0] ee_addr_o,
    input wire logic ee_valid_i,
    input wire logic cfg_loaded_o,
    input wire logic local_bus_reset_out_n_o,
    input wire logic local_irq1_o,
    input wire logic pci_inta_n_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    load_hold_a: assert property (!cfg_loaded_o |-> !local_bus_reset_out_n_o)
        else $error("local side left reset before load");
    ee_step_a: assert property (ee_req_o && ee_valid_i && ee_addr_o != 8'h87 |=>
        ee_req_o && ee_addr_o == $past(ee_addr_o) + 8'h01) else $error("loader skipped");
    load_done_a: assert property (ee_req_o && ee_valid_i && ee_addr_o == 8'h87 |=>
        cfg_loaded_o) else $error("load not finished");
    sw_reset_a: assert property (cfg_wr_i && cfg_loaded_o && cfg_addr_i == 8'h50 &&
        cfg_wdata_i[30] |=> !local_bus_reset_out_n_o) else $error("soft reset missing");
    sw_release_a: assert property (cfg_wr_i && cfg_loaded_o && cfg_addr_i == 8'h50 &&
        !cfg_wdata_i[30] |=> local_bus_reset_out_n_o) else $error("soft reset stuck");
    irq_merge_a: assert property (loc_rd_i && loc_addr_i == 7'h48 |=>
        (loc_rdata_o != 8'h00) == $past(local_irq1_o)) else $error("summary and irq differ");
    inta_gate_a: assert property (!pci_inta_n_o |-> local_irq1_o)
        else $error("inta without request");
    unmapped_zero_a: assert property (loc_rd_i && loc_addr_i > 7'h48 |=>
        loc_rdata_o == 8'h00) else $error("unmapped read not zero");
    rdata_hold_a: assert property (!loc_rd_i ##1 local_bus_reset_out_n_o |->
        $stable(loc_rdata_o)) else $error("read data moved");
endmodule

bind octal_uart_regs octal_uart_regs_sva i_octal_uart_regs_sva (.*);

// file: cfg_eeprom_model.sv
`timescale 1ns/1ps
// Configuration memory; some bytes answer late.
module cfg_eeprom_model (
    input wire logic clk_sys_i,
    input wire logic ee_req_i,
    input wire logic [7:0] ee_addr_i,
    output logic ee_valid_o,
    output logic [7:0] ee_data_o
);
    logic [1:0] wait_reg = 2'h0;
    initial ee_valid_o = 1'b0;
    initial ee_data_o = 8'h00;
    // Data toggles when an answer ends or no request stands, and holds while a late byte waits, so a stale byte never looks fresh.
    // The image sets forwarding in the irq control word and 0x78 in control.
    always @(posedge clk_sys_i) begin
        if (ee_valid_o || !ee_req_i) begin
            ee_valid_o <= 1'b0;
            ee_data_o <= ~ee_data_o;
            wait_reg <= {ee_addr_i[2], 1'b0};
        end else if (wait_reg != 2'h0) begin
            wait_reg <= wait_reg - 2'h1;
        end else begin
            ee_valid_o <= 1'b1;
            ee_data_o <= (ee_addr_i == 8'h74) ? 8'h41 : (ee_addr_i == 8'h7a) ? 8'h78 : 8'h00;
        end
    end
endmodule

// file: octal_uart_regs_bench.sv
`timescale 1ns/1ps
module octal_uart_regs_bench;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [6:0] loc_addr_i = 7'h00;
    logic loc_rd_i = 1'b0, loc_wr_i = 1'b0, cfg_rd_i = 1'b0, cfg_wr_i = 1'b0;
    logic [7:0] loc_wdata_i = 8'h00, cfg_addr_i = 8'h00, tx_pop_i = 8'h00, rx_push_i = 8'h00;
    logic [31:0] cfg_wdata_i = 32'h0, cfg_rdata_o;
    logic [7:0] loc_rdata_o, ee_addr_o, ee_data_i, tx_valid_o, rx_space_o;
    logic ee_req_o, ee_valid_i, cfg_loaded_o, local_bus_reset_out_n_o, local_irq1_o, pci_inta_n_o;
    octal_uart_regs_pkg::chan_ctrl_type chan_ctrl_o [8];
    octal_uart_regs_pkg::chan_stat_type chan_stat_i [8];
    logic [7:0] tx_data_o [8];
    logic [7:0] rx_data_i [8];
    int error_cnt = 0, n_compared = 0, cyc = 0;
    octal_uart_regs i_octal_uart_regs (.*);
    cfg_eeprom_model i_cfg_eeprom_model (.clk_sys_i, .ee_req_i(ee_req_o),
        .ee_addr_i(ee_addr_o), .ee_valid_o(ee_valid_i), .ee_data_o(ee_data_i));
    always #50 clk_sys_i = ~clk_sys_i;
    // --------------
    // Bus tasks; strobes rise one edge after the last fell, never twice per step.
    // --------------
    task automatic tick;
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic lb(input logic w, input logic [6:0] a, input logic [7:0] d);
        tick;
        loc_addr_i = a;
        loc_wdata_i = d;
        loc_wr_i = w;
        loc_rd_i = !w;
        tick;
        loc_wr_i = 1'b0;
        loc_rd_i = 1'b0;
    endtask
    task automatic cb(input logic w, input logic [7:0] a, input logic [31:0] d);
        tick;
        cfg_addr_i = a;
        cfg_wdata_i = d;
        cfg_wr_i = w;
        cfg_rd_i = !w;
        tick;
        cfg_wr_i = 1'b0;
        cfg_rd_i = 1'b0;
    endtask
    // Hang guard; the whole run needs far fewer cycles.
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            results;
        end
    end
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // --------------
    // Scenarios
    // --------------
    task automatic t_boot;
        cb(0, 8'h4c, 0);
        chk("irq ctrl", cfg_rdata_o[7:0], 8'h41);
        chk("bank", chan_ctrl_o[5].line_control_reg[7], 1'b0);
        lb(0, 7'h40, 0);
        chk("ready low", loc_rdata_o, 8'hff);
        lb(0, 7'h44, 0);
        chk("ready high", loc_rdata_o, 8'hff);
        $display("boot test done");
    endtask
    task automatic t_bank;
        lb(1, 7'h1f, 8'h5a);
        lb(1, 7'h1b, 8'h80);
        lb(1, 7'h18, 8'h34);
        lb(1, 7'h19, 8'h12);
        lb(0, 7'h19, 0);
        chk("divisor high", loc_rdata_o, 8'h12);
        chk("divisor low", chan_ctrl_o[3].divisor_low_byte, 8'h34);
        lb(1, 7'h1b, 8'hbf);
        lb(1, 7'h1a, 8'h10);
        lb(1, 7'h1f, 8'h13);
        lb(0, 7'h1b, 0);
        chk("line control", loc_rdata_o, 8'hbf);
        chk("feature", chan_ctrl_o[3].enhanced_feature_reg, 8'h10);
        chk("flow off", chan_ctrl_o[3].flow_off_two, 8'h13);
        lb(1, 7'h1b, 8'h03);
        lb(0, 7'h1f, 0);
        chk("scratch", loc_rdata_o, 8'h5a);
        lb(0, 7'h19, 0);
        chk("write only", loc_rdata_o, 8'h00);
        lb(1, 7'h48, 8'hff);
        lb(0, 7'h48, 0);
        chk("read only", loc_rdata_o, 8'h00);
        lb(0, 7'h4a, 0);
        chk("unmapped", loc_rdata_o, 8'h00);
        $display("bank test done");
    endtask
    task automatic t_fifo;
        for (int i = 0; i < 64; i++) lb(1, 7'h38, i[7:0]);
        chk("tx head", tx_data_o[7], 8'h00);
        chk("valid space", {tx_valid_o[7], rx_space_o[0]}, 2'b11);
        lb(0, 7'h44, 0);
        chk("tx full", loc_rdata_o[3], 1'b0);
        tx_pop_i[7] = 1'b1;
        tick;
        tx_pop_i[7] = 1'b0;
        lb(0, 7'h44, 0);
        chk("tx free", loc_rdata_o[3], 1'b1);
        rx_push_i[0] = 1'b1;
        repeat (9) tick;
        rx_push_i[0] = 1'b0;
        chan_stat_i[6].rx_timeout = 1'b1;
        lb(0, 7'h40, 0);
        chk("rx above", loc_rdata_o[4], 1'b0);
        lb(0, 7'h44, 0);
        chk("rx timeout", loc_rdata_o[6], 1'b0);
        lb(0, 7'h00, 0);
        chk("rx data", loc_rdata_o, 8'h3c);
        lb(0, 7'h40, 0);
        chk("rx at trigger", loc_rdata_o[4], 1'b1);
        $display("fifo test done");
    endtask
    task automatic t_irq;
        chan_stat_i[2].line_irq = 1'b1;
        lb(0, 7'h48, 0);
        chk("masked", loc_rdata_o, 8'h00);
        lb(1, 7'h11, 8'h04);
        lb(0, 7'h48, 0);
        chk("pending", loc_rdata_o, 8'h04);
        chk("inta", pci_inta_n_o, 1'b0);
        cb(1, 8'h4c, 32'h0000_0001);
        tick;
        chk("inta off", pci_inta_n_o, 1'b1);
        chk("merged", local_irq1_o, 1'b1);
        $display("irq test done");
    endtask
    task automatic t_swrst;
        cb(1, 8'h50, 32'h4078_0000);
        chk("local reset", local_bus_reset_out_n_o, 1'b0);
        cb(0, 8'h4c, 0);
        chk("bridge kept", cfg_rdata_o[7:0], 8'h01);
        cb(1, 8'h50, 32'h0078_0000);
        chk("released", local_bus_reset_out_n_o, 1'b1);
        lb(0, 7'h48, 0);
        chk("summary clear", loc_rdata_o, 8'h00);
        $display("soft reset test done");
    endtask
    // Reset is held for 20 cycles, then the run waits for the load.
    initial begin
        for (int i = 0; i < 8; i++) begin
            chan_stat_i[i] = '0;
            rx_data_i[i] = 8'h3c;
        end
        repeat (20) tick;
        rst_n_i = 1'b1;
        while (cfg_loaded_o !== 1'b1) tick;
        t_boot;
        t_bank;
        t_fifo;
        t_irq;
        t_swrst;
        results;
    end
endmodule
